// [tacsl_asserts.sv]
// tacsl_asserts: wire-level checks on the reader/tag link
// assumes one tag on the link and clk_en_i tied high on both ends
`timescale 1ns/1ps
module tacsl_asserts
    import tacsl_pkg::*;
(
    // clock and reset
    input wire logic       mclk_i,
    input wire logic       rst_b_i,
    // command side
    input wire logic       cmd_valid,
    input wire logic [7:0] cmd_byte0,
    input wire logic [7:0] cmd_byte1,
    input wire logic       cmd_two,
    // reply side
    input wire logic       rsp_valid,
    input wire logic [7:0] rsp_handle,
    input wire logic       rsp_collide,
    input wire logic       rsp_bad
);
    wire       is_start   = cmd_valid && cmd_two && cmd_byte0 == CMD_INVENTORY && cmd_byte1 == SUB_START_INV;
    wire       is_zero    = cmd_valid && cmd_two && cmd_byte0 == CMD_INVENTORY && cmd_byte1 == SUB_SLOT_ZERO;
    wire       is_probe   = cmd_valid && !cmd_two && cmd_byte0[3:0] == PROBE_CODE;
    wire       is_pick    = cmd_valid && cmd_two && cmd_byte0 == CMD_PICK_TAG;
    wire [3:0] probe_slot = cmd_byte0[7:4];
    logic       inv_ff;
    logic       sel_ff;
    logic [3:0] last_ff;
    // inv_ff: tag took start_inventory; sel_ff: tag echoed a pick
    always_ff @(posedge mclk_i) begin
        if (!rst_b_i) begin
            inv_ff  <= 1'b0;
            sel_ff  <= 1'b0;
            last_ff <= 4'h0;
        end else begin
            if (is_start && !sel_ff)
                inv_ff <= 1'b1;
            if (rsp_valid && $past(is_pick))
                sel_ff <= 1'b1;
            if (is_start || is_zero)
                last_ff <= 4'h0;
            else if (is_probe)
                last_ff <= probe_slot;
        end
    end
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!rst_b_i);
    chk_reply_after_cmd: assert property (rsp_valid |-> $past(cmd_valid))
        else $error("reply without a command one cycle before");
    chk_start_reply_now: assert property (is_start && !sel_ff |=> rsp_valid)
        else $error("start_inventory not answered");
    chk_ready_stays_quiet: assert property ((is_zero || is_probe) && !inv_ff |=> !rsp_valid)
        else $error("slot command answered before start_inventory");
    chk_zero_slot_reply: assert property ($past(is_zero) && rsp_valid |-> rsp_handle[3:0] == 4'h0)
        else $error("slot_zero_call answered with nonzero slot");
    chk_probe_slot_match: assert property (is_probe |=> !rsp_valid || rsp_handle[3:0] == $past(probe_slot))
        else $error("probe answered from another slot");
    chk_pick_echo_handle: assert property ($past(is_pick) && rsp_valid |-> rsp_handle == $past(cmd_byte1))
        else $error("pick reply differs from handle sent");
    chk_selected_quiet: assert property ((is_start || is_zero || is_probe) && sel_ff |=> !rsp_valid)
        else $error("selected tag answered anticollision command");
    chk_probe_byte_form: assert property (cmd_valid && !cmd_two |-> is_probe && probe_slot != 4'h0)
        else $error("bad single-byte probe");
    chk_probe_ascending: assert property (is_probe |-> probe_slot > last_ff)
        else $error("probe slots not ascending");
endmodule

// [tacsl_link_if.sv]
// tacsl_link_if: command and reply channel between reader and tag
// assumes framing and crc are handled around it; byte-level transfers
`timescale 1ns/1ps
interface tacsl_link_if;
    logic       cmd_valid;
    logic [7:0] cmd_byte0;
    logic [7:0] cmd_byte1;
    logic       cmd_two;
    logic       rsp_valid;
    logic [7:0] rsp_handle;
    logic       rsp_collide;
    logic       rsp_bad;
    modport tag    (input cmd_valid, cmd_byte0, cmd_byte1, cmd_two,
                    output rsp_valid, rsp_handle);
    modport reader (output cmd_valid, cmd_byte0, cmd_byte1, cmd_two,
                    input rsp_valid, rsp_handle, rsp_collide, rsp_bad);
endinterface

// [tacsl_pkg.sv]
// tacsl_pkg: command codes, field positions and timing counts for the tag
// anticollision slot logic; shared by the tag end and the reader end
package tacsl_pkg;
    localparam logic [7:0] CMD_INVENTORY  = 8'h06;
    localparam logic [7:0] SUB_START_INV  = 8'h00;
    localparam logic [7:0] SUB_SLOT_ZERO  = 8'h04;
    localparam logic [3:0] PROBE_CODE     = 4'h6;
    localparam logic [7:0] CMD_PICK_TAG   = 8'h0E;
    localparam int         PROBE_CODE_LSB = 0;
    localparam int         PROBE_SLOT_LSB = 4;
    localparam int         SLOT_W         = 4;
    localparam int         HANDLE_W       = 8;
    localparam int         LAST_SLOT      = 15;
    localparam int         NUM_SLOTS      = 16;
    localparam logic [15:0] LFSR_SEED     = 16'hACE1;
    localparam int         REPLY_WAIT_NS  = 200;
    localparam int         CLK_NS         = 10;
    localparam int         REPLY_WAIT_CYC = REPLY_WAIT_NS / CLK_NS;
    localparam int         MAX_STORE      = 16;
    localparam logic [7:0] CMD_KIND_FIRST = 8'h00;
endpackage

// [tacsl_reader.sv]
// tacsl_reader: reader end running the slot search
// assumes the link merges tag replies into valid, collide and bad flags
`timescale 1ns/1ps
module tacsl_reader
    import tacsl_pkg::*;
#(
    parameter int WAIT_CYC = REPLY_WAIT_CYC
)
(
    // clock and control
    input  wire logic       mclk_i,
    input  wire logic       rst_b_i,
    input  wire logic       clk_en_i,
    input  wire logic       go_i,
    // link
    tacsl_link_if.reader    link,
    // user side results
    output logic            found_valid_o,
    output logic [7:0]      found_handle_o,
    output logic            busy_o
);
    typedef enum logic [2:0] {RS_IDLE, RS_SEND, RS_WAIT, RS_PICK, RS_PICKW, RS_DRAIN} tacsl_rstate_t;
    typedef enum logic [1:0] {CK_START, CK_ZERO, CK_PROBE} tacsl_kind_t;
    typedef struct packed {
        tacsl_rstate_t st;
        tacsl_kind_t   kind;
        logic [3:0]    slot;
        logic [7:0]    tmr;
        logic          coll;
        logic [4:0]    cnt;
        logic [4:0]    idx;
        logic          cv;
        logic [7:0]    b0;
        logic [7:0]    b1;
        logic          two;
        logic          fv;
        logic [7:0]    fh;
    } tacsl_rd_t;

    tacsl_rd_t    cur_ff;
    tacsl_rd_t    nxt_cur;
    logic [7:0]   store_ff [MAX_STORE];
    logic         wr_en;

    always_comb begin
        nxt_cur    = cur_ff;
        nxt_cur.cv = 1'b0;
        nxt_cur.fv = 1'b0;
        wr_en      = 1'b0;
        case (cur_ff.st)
            RS_IDLE: begin
                if (go_i) begin
                    nxt_cur.st   = RS_SEND;
                    nxt_cur.kind = CK_START;                           // [RULE10]
                end
            end
            RS_SEND: begin
                nxt_cur.cv  = 1'b1;
                nxt_cur.tmr = '0;
                nxt_cur.st  = RS_WAIT;
                case (cur_ff.kind)
                    CK_START: begin
                        nxt_cur.b0  = CMD_INVENTORY;
                        nxt_cur.b1  = SUB_START_INV;
                        nxt_cur.two = 1'b1;
                    end
                    CK_ZERO: begin
                        nxt_cur.b0   = CMD_INVENTORY;
                        nxt_cur.b1   = SUB_SLOT_ZERO;
                        nxt_cur.two  = 1'b1;
                        nxt_cur.coll = 1'b0;
                        nxt_cur.cnt  = '0;
                    end
                    default: begin
                        nxt_cur.b0 = {cur_ff.slot, PROBE_CODE};        // [RULE8] [RULE12]
                        nxt_cur.two = 1'b0;
                    end
                endcase
            end
            RS_WAIT: begin
                nxt_cur.tmr = cur_ff.tmr + 8'h01;
                if (link.rsp_valid && !link.rsp_collide && !link.rsp_bad) begin
                    // single clean answer kept [RULE15]
                    nxt_cur.fh = link.rsp_handle;
                    nxt_cur.fv = 1'b1;
                    nxt_cur.st = RS_PICK;
                    if (cur_ff.kind != CK_START && cur_ff.cnt < 5'(MAX_STORE)) begin
                        wr_en = 1'b1;                                  // [RULE11]
                        nxt_cur.cnt = cur_ff.cnt + 5'h01;
                    end
                end else if (link.rsp_valid || cur_ff.tmr == 8'(WAIT_CYC)) begin
                    if (link.rsp_valid) begin
                        nxt_cur.coll = 1'b1;
                    end
                    if (cur_ff.kind == CK_START) begin
                        nxt_cur.kind = link.rsp_valid ? CK_ZERO : CK_START; // [RULE10]
                        nxt_cur.st   = RS_SEND;
                    end else begin
                        nxt_cur.st = RS_PICK;
                        nxt_cur.fv = 1'b0;
                    end
                end
            end
            RS_PICK: begin
                // pick only after a clean single answer; a stray reply here must not re-pick a stale handle
                if (cur_ff.fv) begin
                    nxt_cur.cv  = 1'b1;
                    nxt_cur.b0  = CMD_PICK_TAG;
                    nxt_cur.b1  = cur_ff.fh;
                    nxt_cur.two = 1'b1;
                end
                nxt_cur.st  = RS_PICKW;
                nxt_cur.tmr = '0;
            end
            RS_PICKW: begin
                nxt_cur.tmr = cur_ff.tmr + 8'h01;
                if (cur_ff.tmr == 8'(WAIT_CYC)) begin
                    if (cur_ff.kind == CK_START) begin
                        nxt_cur.st = RS_SEND;                          // [RULE10]
                    end else if (cur_ff.kind == CK_ZERO || cur_ff.slot != 4'(LAST_SLOT)) begin
                        nxt_cur.kind = CK_PROBE;
                        nxt_cur.slot = cur_ff.kind == CK_ZERO ? 4'h1 : cur_ff.slot + 4'h1;
                        nxt_cur.st   = RS_SEND;
                    end else begin
                        nxt_cur.idx = '0;
                        nxt_cur.st  = RS_DRAIN;                        // [RULE13]
                    end
                end
            end
            default: begin
                if (cur_ff.idx < cur_ff.cnt) begin
                    nxt_cur.cv  = 1'b1;
                    nxt_cur.b0  = CMD_PICK_TAG;
                    nxt_cur.b1  = store_ff[cur_ff.idx[3:0]];
                    nxt_cur.two = 1'b1;
                    nxt_cur.idx = cur_ff.idx + 5'h01;
                end else begin
                    nxt_cur.kind = cur_ff.coll ? CK_ZERO : CK_START;   // [RULE14]
                    nxt_cur.slot = '0;
                    nxt_cur.st   = cur_ff.coll ? RS_SEND : RS_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge mclk_i) begin
        if (!rst_b_i) begin
            cur_ff <= '0;
        end else if (clk_en_i) begin
            cur_ff <= nxt_cur;
            if (wr_en) begin
                store_ff[cur_ff.cnt[3:0]] <= link.rsp_handle;
            end
        end
    end

    assign link.cmd_valid = cur_ff.cv;
    assign link.cmd_byte0 = cur_ff.b0;
    assign link.cmd_byte1 = cur_ff.b1;
    assign link.cmd_two   = cur_ff.two;
    assign found_valid_o  = cur_ff.fv;
    assign found_handle_o = cur_ff.fh;
    assign busy_o         = cur_ff.st != RS_IDLE;
endmodule

// [tacsl_tag.sv]
// tacsl_tag: tag end of the anticollision slot logic
// assumes one command per cmd_valid pulse and a one-clock domain
`timescale 1ns/1ps
// Operation
// [RULE1] start_inventory in ready: enter inventory, reply
// [RULE2] start_inventory ignores slot_index entirely
// [RULE3] slot commands only answered in inventory
// [RULE4] late tag stays ready, silent to slots
// [RULE5] slot_zero_call renews the low four bits
// [RULE6] slot_index held until renewal
// [RULE7] reply on slot_zero_call only if zero
// [RULE8] probe byte: low code six, high slot
// [RULE9] probe replies only on slot match
// [RULE10] reader starts with start_inventory, retries
// [RULE11] reader stores clean slot-zero answer, picks
// [RULE12] reader probes slots one to fifteen
// [RULE13] reader picks stored handles after slot fifteen
// [RULE14] reader restarts slot_zero on collisions
// [RULE15] reader keeps only clean decoded handles
// [RULE16] after reset ready, only start_inventory accepted
// [RULE17] start_inventory in inventory renews handle
// [RULE18] pick_tag match selects; mismatch deselects
// [RULE19] selected tag ignores anticollision commands
// [RULE20] reply is handle byte, crc framed outside
// [RULE21] free-running generator sampled per command
module tacsl_tag
    import tacsl_pkg::*;
(
    // clock and control
    input  wire logic       mclk_i,
    input  wire logic       rst_b_i,
    input  wire logic       clk_en_i,
    // link
    tacsl_link_if.tag       link,
    // user side status
    output logic [7:0]      handle_o,
    output logic [2:0]      state_o
);
    typedef enum logic [2:0] {ST_READY, ST_INVENTORY, ST_SELECTED, ST_DESELECTED} tacsl_tstate_t;
    typedef struct packed {
        tacsl_tstate_t st;
        logic [15:0]   lfsr;
        logic [7:0]    handle;
        logic          rsp;
    } tacsl_tag_t;

    tacsl_tag_t cur_ff;
    tacsl_tag_t nxt_cur;
    logic       is_start;
    logic       is_zero;
    logic       is_probe;
    logic       is_pick;

    always_comb begin
        is_start = link.cmd_two && link.cmd_byte0 == CMD_INVENTORY && link.cmd_byte1 == SUB_START_INV;
        is_zero  = link.cmd_two && link.cmd_byte0 == CMD_INVENTORY && link.cmd_byte1 == SUB_SLOT_ZERO;
        // probe has nonzero slot; zero is reserved [RULE8]
        is_probe = !link.cmd_two && link.cmd_byte0[PROBE_CODE_LSB +: SLOT_W] == PROBE_CODE
                   && link.cmd_byte0[PROBE_SLOT_LSB +: SLOT_W] != '0;
        is_pick  = link.cmd_two && link.cmd_byte0 == CMD_PICK_TAG;
    end

    always_comb begin
        nxt_cur     = cur_ff;
        nxt_cur.rsp = 1'b0;
        // free-running generator [RULE21]
        nxt_cur.lfsr = {cur_ff.lfsr[14:0], cur_ff.lfsr[15] ^ cur_ff.lfsr[13] ^ cur_ff.lfsr[12] ^ cur_ff.lfsr[10]};
        if (link.cmd_valid) begin
            case (cur_ff.st)
                ST_READY: begin
                    // only start_inventory leaves ready [RULE16] [RULE4]
                    if (is_start) begin
                        nxt_cur.st     = ST_INVENTORY;                 // [RULE1]
                        nxt_cur.handle = cur_ff.lfsr[7:0];             // [RULE2]
                        nxt_cur.rsp    = 1'b1;
                    end
                end
                ST_INVENTORY: begin
                    if (is_start) begin
                        nxt_cur.handle = cur_ff.lfsr[7:0];             // [RULE17]
                        nxt_cur.rsp    = 1'b1;
                    end else if (is_zero) begin
                        nxt_cur.handle[SLOT_W-1:0] = cur_ff.lfsr[SLOT_W-1:0];  // [RULE5]
                        nxt_cur.rsp    = cur_ff.lfsr[SLOT_W-1:0] == '0;        // [RULE7]
                    end else if (is_probe) begin
                        // slot_index untouched here [RULE6] [RULE3]
                        nxt_cur.rsp = link.cmd_byte0[PROBE_SLOT_LSB +: SLOT_W] == cur_ff.handle[SLOT_W-1:0]; // [RULE9]
                    end else if (is_pick && link.cmd_byte1 == cur_ff.handle) begin
                        nxt_cur.st  = ST_SELECTED;                     // [RULE18]
                        nxt_cur.rsp = 1'b1;
                    end
                end
                ST_SELECTED: begin
                    // anticollision commands fall through silently [RULE19]
                    if (is_pick) begin
                        if (link.cmd_byte1 == cur_ff.handle) begin
                            nxt_cur.rsp = 1'b1;
                        end else begin
                            nxt_cur.st = ST_DESELECTED;                // [RULE18]
                        end
                    end
                end
                default: begin
                    if (is_pick && link.cmd_byte1 == cur_ff.handle) begin
                        nxt_cur.st  = ST_SELECTED;
                        nxt_cur.rsp = 1'b1;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge mclk_i) begin
        if (!rst_b_i) begin
            cur_ff <= '{st: ST_READY, lfsr: LFSR_SEED, handle: LFSR_SEED[7:0], rsp: 1'b0};
        end else if (clk_en_i) begin
            cur_ff <= nxt_cur;
        end
    end

    // handle byte only; crc and framing appended by the frame layer [RULE20]
    assign link.rsp_valid  = cur_ff.rsp;
    assign link.rsp_handle = cur_ff.handle;
    assign handle_o        = cur_ff.handle;
    assign state_o         = cur_ff.st;
endmodule

// [tacsl_tb.sv]
// tacsl_tb: reader/tag pair plus a second tag driven directly by the bench
// assumes tacsl_pkg, tacsl_link_if, tacsl_tag and tacsl_reader compiled first
`timescale 1ns/1ps
module tacsl_tb;
    import tacsl_pkg::*;
    logic       mclk_i;
    logic       rst_b_i;
    logic       go_i;
    logic       en_b;
    logic       got;
    logic       fv;
    logic       busy;
    logic [7:0] h1;
    logic [7:0] h2;
    logic [7:0] fh;
    logic [7:0] gh;
    logic [7:0] pre;
    logic [7:0] wrong;
    logic [2:0] s1;
    logic [2:0] s2;
    int         num_errors = 0;
    int         num_checks = 0;
    int         cyc = 0;
    int         founds = 0;
    int         n;
    int         m_st = 0;
    logic [7:0] m_hd = LFSR_SEED[7:0];
    integer     seed = 32'hf0fa3b66;
    tacsl_link_if lk();
    tacsl_link_if lk2();
    tacsl_tag u_tacsl_tag (.mclk_i(mclk_i), .rst_b_i(rst_b_i), .clk_en_i(1'b1), .link(lk), .handle_o(h1),
                           .state_o(s1));
    tacsl_tag u_tacsl_tag_b (.mclk_i(mclk_i), .rst_b_i(rst_b_i), .clk_en_i(en_b), .link(lk2), .handle_o(h2),
                             .state_o(s2));
    tacsl_reader #(.WAIT_CYC(3)) u_tacsl_reader (.mclk_i(mclk_i), .rst_b_i(rst_b_i), .clk_en_i(1'b1), .go_i(go_i),
        .link(lk), .found_valid_o(fv), .found_handle_o(fh), .busy_o(busy));
    tacsl_asserts u_tacsl_asserts (.mclk_i(mclk_i), .rst_b_i(rst_b_i), .cmd_valid(lk.cmd_valid),
        .cmd_byte0(lk.cmd_byte0), .cmd_byte1(lk.cmd_byte1), .cmd_two(lk.cmd_two), .rsp_valid(lk.rsp_valid),
        .rsp_handle(lk.rsp_handle), .rsp_collide(lk.rsp_collide), .rsp_bad(lk.rsp_bad));
    initial begin
        mclk_i = 1'b0;
        forever #5 mclk_i = ~mclk_i;
    end
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        num_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic give_verdict();
        $display("checks %0d errors %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    task automatic send(input logic [7:0] b0, input logic [7:0] b1, input logic two);
        logic exp_rsp;
        @(negedge mclk_i);
        lk2.cmd_byte0 = b0;
        lk2.cmd_byte1 = b1;
        lk2.cmd_two   = two;
        lk2.cmd_valid = 1'b1;
        @(negedge mclk_i);
        lk2.cmd_valid = 1'b0;
        got = lk2.rsp_valid;
        gh  = lk2.rsp_handle;
        // model of the directly driven tag; only the random bits are taken from the tag
        exp_rsp = 1'b0;
        if (en_b) begin
            if (two && b0 == CMD_INVENTORY && b1 == SUB_START_INV && m_st < 2) begin
                m_st    = 1;
                m_hd    = h2;
                exp_rsp = 1'b1;
            end else if (two && b0 == CMD_INVENTORY && b1 == SUB_SLOT_ZERO && m_st == 1) begin
                m_hd[3:0] = h2[3:0];
                exp_rsp   = m_hd[3:0] == 4'h0;
            end else if (!two && b0[3:0] == PROBE_CODE && b0[7:4] != 4'h0 && m_st == 1) begin
                exp_rsp = b0[7:4] == m_hd[3:0];
            end else if (two && b0 == CMD_PICK_TAG && m_st != 0) begin
                if (b1 == m_hd) begin
                    m_st    = 2;
                    exp_rsp = 1'b1;
                end else if (m_st == 2) begin
                    m_st = 3;
                end
            end
        end
        check({7'h00, got}, {7'h00, exp_rsp});
        check(h2, m_hd);
        check({5'h00, s2}, 8'(m_st));
        if (exp_rsp)
            check(gh, m_hd);
    endtask
    always @(posedge mclk_i) begin
        cyc++;
        if (cyc == 30000) begin
            num_errors++;
            give_verdict();
        end
    end
    always @(negedge mclk_i) if (fv === 1'b1) begin
        founds++;
        check(fh, h1);
    end
    initial begin
        rst_b_i = 1'b0;
        go_i = 1'b0;
        en_b = 1'b1;
        lk2.cmd_valid = 1'b0;
        lk2.cmd_byte0 = 8'h00;
        lk2.cmd_byte1 = 8'h00;
        lk2.cmd_two = 1'b0;
        lk2.rsp_collide = 1'b0;
        lk2.rsp_bad = 1'b0;
        lk.rsp_collide = 1'b0;
        lk.rsp_bad = 1'b0;
        repeat (5) @(negedge mclk_i);
        rst_b_i = 1'b1;
        send(CMD_INVENTORY, SUB_SLOT_ZERO, 1'b1);
        check({7'h00, got}, 8'h00);
        for (int s = 1; s <= LAST_SLOT; s++) begin
            send({4'(s), PROBE_CODE}, 8'h00, 1'b0);
            check({7'h00, got}, 8'h00);
        end
        send(CMD_PICK_TAG, h2, 1'b1);
        check({5'h00, s2}, 8'h00);
        en_b = 1'b0;
        send(CMD_INVENTORY, SUB_START_INV, 1'b1);
        check({7'h00, got}, 8'h00);
        en_b = 1'b1;
        $display("test ready done");
        repeat (2) begin
            send(CMD_INVENTORY, SUB_START_INV, 1'b1);
            check({7'h00, got}, 8'h01);
            check(gh, h2);
            check({5'h00, s2}, 8'h01);
        end
        repeat (8) begin
            pre = h2;
            send(CMD_INVENTORY, SUB_SLOT_ZERO, 1'b1);
            check({4'h0, h2[7:4]}, {4'h0, pre[7:4]});
            check({7'h00, got}, {7'h00, h2[3:0] == 4'h0});
            pre = h2;
            send({4'h0, PROBE_CODE}, 8'h00, 1'b0);
            check({7'h00, got}, 8'h00);
            for (int s = 1; s <= LAST_SLOT; s++) begin
                send({4'(s), PROBE_CODE}, 8'h00, 1'b0);
                check({7'h00, got}, {7'h00, pre[3:0] == 4'(s)});
                check(h2, pre);
            end
        end
        $display("test slots done");
        wrong = h2 ^ (8'($random(seed)) | 8'h01);
        send(CMD_PICK_TAG, wrong, 1'b1);
        check({5'h00, s2}, 8'h01);
        send(CMD_PICK_TAG, h2, 1'b1);
        check(gh, h2);
        check({5'h00, s2}, 8'h02);
        send(CMD_INVENTORY, SUB_START_INV, 1'b1);
        check({7'h00, got}, 8'h00);
        send(CMD_INVENTORY, SUB_SLOT_ZERO, 1'b1);
        check({7'h00, got}, 8'h00);
        send({h2[3:0] | 4'h1, PROBE_CODE}, 8'h00, 1'b0);
        check({7'h00, got}, 8'h00);
        send(CMD_PICK_TAG, wrong, 1'b1);
        check({5'h00, s2}, 8'h03);
        $display("test pick done");
        @(negedge mclk_i);
        go_i = 1'b1;
        @(negedge mclk_i);
        go_i = 1'b0;
        n = 0;
        for (int i = 0; i < 5000 && busy !== 1'b0; i++) begin
            @(negedge mclk_i);
            if (lk.rsp_valid === 1'b1) begin
                n++;
                lk.rsp_collide = (n == 1) || (n < 4 && ($random(seed) & 1) != 0);
                lk.rsp_bad     = n == 4;
            end else begin
                lk.rsp_collide = 1'b0;
                lk.rsp_bad     = 1'b0;
            end
        end
        check({7'h00, busy}, 8'h00);
        check({5'h00, s1}, 8'h02);
        check({7'h00, founds != 0}, 8'h01);
        $display("test search done");
        give_verdict();
    end
endmodule
